//--- rtl/i2csf_pkg.sv
package i2csf_pkg;

	// register indices; byte address is four times the low ten index bits
	localparam logic [31:0] I2CSF_CTRL_IDX   = 32'h40041b50;
	localparam logic [31:0] I2CSF_STATUS_IDX = 32'h40041b51;
	localparam logic [31:0] I2CSF_FLAGS_IDX  = 32'h40041b52;
	localparam logic [31:0] I2CSF_SHIFT_IDX  = 32'h40041b53;
	localparam logic [31:0] I2CSF_OWN_IDX    = 32'h40041b54;

	// low index bits compared against paddr[11:2]
	localparam int I2CSF_DEC_W = 10;

	// reset values
	localparam logic [7:0] I2CSF_STATUS_RST = 8'h00;
	localparam logic [7:0] I2CSF_FLAGS_RST  = 8'h00;

	// status register fields
	localparam int I2CSF_ST_MASTER = 7;
	localparam int I2CSF_ST_ARB    = 6;
	localparam int I2CSF_ST_EXT    = 5;
	localparam int I2CSF_ST_MATCH  = 4;
	localparam int I2CSF_ST_DIR    = 3;
	localparam int I2CSF_ST_ACK    = 2;
	localparam int I2CSF_ST_START  = 1;
	localparam int I2CSF_ST_STOP   = 0;

	// flag register fields
	localparam int I2CSF_FL_STCLR  = 7;
	localparam int I2CSF_FL_BUSY   = 6;
	localparam int I2CSF_FL_ISTEN  = 1;
	localparam int I2CSF_FL_RSV    = 0;

	// control register fields
	localparam int I2CSF_CT_EN     = 7;
	localparam int I2CSF_CT_EXIT   = 6;
	localparam int I2CSF_CT_WREL   = 5;
	localparam int I2CSF_CT_START  = 1;
	localparam int I2CSF_CT_WAKE   = 0;

	// bit counter values on the serial clock
	localparam logic [3:0] I2CSF_CNT_IDLE  = 4'h0;
	localparam logic [3:0] I2CSF_CNT_FIRST = 4'h1;
	localparam logic [3:0] I2CSF_CNT_ADDR  = 4'h8;
	localparam logic [3:0] I2CSF_CNT_ACK   = 4'h9;

	// extension code patterns on the upper address nibble
	localparam logic [3:0] I2CSF_EXT_ZERO  = 4'h0;
	localparam logic [3:0] I2CSF_EXT_ONE   = 4'hf;

endpackage

//--- rtl/i2csf_sync.sv
`timescale 1ns/1ps
module i2csf_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	// asynchronous levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	import i2csf_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} i2csf_sync_s;

	i2csf_sync_s st;
	i2csf_sync_s next_st;

	always_comb begin
		next_st = st;
		if (ce_in) begin
			next_st.meta = async_in;
			next_st.sync = st.meta;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.sync;

endmodule

//--- rtl/i2csf_line_events.sv
`timescale 1ns/1ps
module i2csf_line_events (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	// synchronised lines
	input  wire logic scl_in,
	input  wire logic sda_in,
	// one-cycle events
	output logic      scl_rise_out,
	output logic      scl_fall_out,
	output logic      start_out,
	output logic      stop_out
);
	import i2csf_pkg::*;

	typedef struct packed {
		logic scl;
		logic sda;
	} i2csf_lev_s;

	i2csf_lev_s st;
	i2csf_lev_s next_st;

	always_comb begin
		next_st = st;
		if (ce_in) begin
			next_st.scl = scl_in;
			next_st.sda = sda_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	// data moving while clock stays high marks start or stop
	assign scl_rise_out = ce_in & ~st.scl & scl_in;
	assign scl_fall_out = ce_in & st.scl & ~scl_in;
	assign start_out    = ce_in & st.scl & scl_in & st.sda & ~sda_in;
	assign stop_out     = ce_in & st.scl & scl_in & ~st.sda & sda_in;

endmodule

//--- rtl/i2csf_top.sv
// Behaviour
// (R1) status and flag registers read all zeros after reset
// (R2) software reads status only with start trigger set or during a wait
// (R3) after wake enable falls, status view holds until next start or stop
// (R4) with wake-up, software enables stop interrupt and reads status afterwards
// (R5) master flag set on start generation, cleared on stop, arb loss, exit, disable
// (R6) arbitration loss sets arb-lost flag and clears master flag together
// (R7) any completed status read clears the arb-lost flag
// (R8) extension flag set at 8th rise for nibble 0000 or 1111
// (R9) address match flag set at 8th rise when address equals own address
// (R10) receive leaves data released; send drives latch after first byte's 9th clock
// (R11) direction set by start generation, master write bit, or slave read request
// (R12) wait release at 9th clock in send clears direction and releases data
// (R13) ack flag set on low data at 9th rise, cleared next byte
// (R14) start flag set on start, cleared on stop or byte after address
// (R15) stop flag set on stop, cleared on next address byte or wake fall
// (R16) flag register: bit7 start-cleared, bit6 busy, bits5-2 zero, bits1-0 writable
// (R17) prohibited reservation on busy bus clears trigger and sets start-cleared flag
// (R18) busy set on start or enable with initial-start zero; cleared on stop
// (R19) initial-start enable lets a start go at once; clears on start
// (R20) software confirms bus is idle before a start with initial-start enable
// (R21) reservation prohibit changes only by software write or reset
// (R22) initial-start and prohibit bits written only while disabled
// (R23) permitted reservation generates the start once the bus is released
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module i2csf_top (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// serial lines
	input  wire logic        serial_clock_line_in,
	input  wire logic        serial_data_line_in,
	output logic             serial_data_line_out,
	output logic             serial_data_line_oe_n_out
);
	import i2csf_pkg::*;

	typedef struct packed {
		logic       en;
		logic       trig;
		logic       wake;
		logic       wake_hold;
		logic [6:0] own;
		logic [7:0] shout;
		logic [7:0] shin;
		logic       master;
		logic       arb;
		logic       ext;
		logic       match;
		logic       dir;
		logic       ack;
		logic       std;
		logic       spd;
		logic       stcf;
		logic       busy;
		logic       isten;
		logic       rsv;
		logic [3:0] cnt;
		logic       addr_ph;
		logic       gen;
		logic [7:0] view;
		logic       oe_n;
		logic [7:0] rdata;
		logic       pready;
		logic       slverr;
	} i2csf_state_s;

	localparam i2csf_state_s ST_RESET = '{
		own: 7'h00, shout: 8'h00, shin: 8'h00, cnt: I2CSF_CNT_IDLE,
		view: I2CSF_STATUS_RST, rdata: 8'h00, oe_n: 1'b1, default: 1'b0
	};

	i2csf_state_s st;
	i2csf_state_s next_st;

	logic [1:0] lines_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;

	i2csf_sync #(
		.WIDTH (2)
	) u_sync (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.ce_in    (ce_in),
		.async_in ({serial_clock_line_in, serial_data_line_in}),
		.sync_out (lines_s)
	);

	assign scl_s = lines_s[1];
	assign sda_s = lines_s[0];

	i2csf_line_events u_events (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.ce_in        (ce_in),
		.scl_in       (scl_s),
		.sda_in       (sda_s),
		.scl_rise_out (scl_rise),
		.scl_fall_out (scl_fall),
		.start_out    (start_det),
		.stop_out     (stop_det)
	);

	function automatic logic hit(input logic [11:0] a, input logic [31:0] idx);
		hit = (a[11:2] == idx[I2CSF_DEC_W-1:0]);
	endfunction

	function automatic logic [7:0] status_byte(input i2csf_state_s s);
		logic [7:0] b;
		b = 8'h00;
		b[I2CSF_ST_MASTER] = s.master;
		b[I2CSF_ST_ARB]    = s.arb;
		b[I2CSF_ST_EXT]    = s.ext;
		b[I2CSF_ST_MATCH]  = s.match;
		b[I2CSF_ST_DIR]    = s.dir;
		b[I2CSF_ST_ACK]    = s.ack;
		b[I2CSF_ST_START]  = s.std;
		b[I2CSF_ST_STOP]   = s.spd;
		status_byte = b;
	endfunction

	logic       acc;
	logic       wr;
	logic       rd_status;
	logic       mapped;
	logic [7:0] rd_mux;
	logic [7:0] wd;
	logic [3:0] cnt_new;
	logic [7:0] addr_byte;
	logic [2:0] tx_idx;

	always_comb begin
		acc       = psel_in & penable_in & st.pready;
		wr        = acc & pwrite_in & ~st.slverr;
		rd_status = acc & ~pwrite_in & hit(paddr_in, I2CSF_STATUS_IDX);
		wd        = pwdata_in[7:0];
		mapped    = hit(paddr_in, I2CSF_CTRL_IDX) | hit(paddr_in, I2CSF_STATUS_IDX) |
			hit(paddr_in, I2CSF_FLAGS_IDX) | hit(paddr_in, I2CSF_SHIFT_IDX) | hit(paddr_in, I2CSF_OWN_IDX);
		rd_mux    = 8'h00;
		if (hit(paddr_in, I2CSF_CTRL_IDX)) begin
			rd_mux[I2CSF_CT_EN]   = st.en;
			rd_mux[I2CSF_CT_WAKE] = st.wake;
		end
		if (hit(paddr_in, I2CSF_STATUS_IDX)) begin
			rd_mux = st.view;
		end
		if (hit(paddr_in, I2CSF_FLAGS_IDX)) begin
			rd_mux[I2CSF_FL_STCLR] = st.stcf; // R16
			rd_mux[I2CSF_FL_BUSY]  = st.busy;
			rd_mux[I2CSF_FL_ISTEN] = st.isten;
			rd_mux[I2CSF_FL_RSV]   = st.rsv;
		end
		if (hit(paddr_in, I2CSF_SHIFT_IDX)) begin
			rd_mux = st.shin;
		end
		if (hit(paddr_in, I2CSF_OWN_IDX)) begin
			rd_mux = {st.own, 1'b0};
		end
		cnt_new   = (st.cnt == I2CSF_CNT_ACK) ? I2CSF_CNT_FIRST : st.cnt + 4'h1;
		addr_byte = {st.shin[6:0], sda_s};
		tx_idx    = (st.cnt == I2CSF_CNT_ACK) ? 3'h7 : 3'h7 - st.cnt[2:0];
	end

	always_comb begin
		next_st = st;
		if (ce_in) begin
			// apb answer one cycle into the access phase
			next_st.pready = psel_in & penable_in & ~st.pready;
			if (psel_in & penable_in & ~st.pready) begin
				next_st.rdata  = rd_mux;
				next_st.slverr = ~mapped;
			end
			if (rd_status) begin
				next_st.arb = 1'b0; // R7
			end
			// status view frozen while wake-up is in use
			if (!(st.wake | st.wake_hold)) begin
				next_st.view = status_byte(st); // R3
			end
			if (!st.en) begin
				next_st.master    = 1'b0; // R5
				next_st.arb       = 1'b0;
				next_st.ext       = 1'b0;
				next_st.match     = 1'b0;
				next_st.dir       = 1'b0;
				next_st.ack       = 1'b0;
				next_st.std       = 1'b0;
				next_st.spd       = 1'b0;
				next_st.stcf      = 1'b0; // R17
				next_st.busy      = 1'b0; // R18
				next_st.trig      = 1'b0;
				next_st.gen       = 1'b0;
				next_st.addr_ph   = 1'b0;
				next_st.wake_hold = 1'b0;
				next_st.cnt       = I2CSF_CNT_IDLE;
				next_st.oe_n      = 1'b1;
			end else begin
				// start generation or reservation
				if (st.trig & ~st.gen & ~st.master) begin
					if (!st.busy) begin
						next_st.gen    = 1'b1; // R19 R23
						next_st.trig   = 1'b0;
						next_st.master = 1'b1; // R5
						next_st.dir    = 1'b1; // R11
						next_st.oe_n   = 1'b0;
					end else if (st.rsv) begin
						next_st.trig = 1'b0; // R17
						next_st.stcf = 1'b1;
					end
				end
				if (start_det) begin
					next_st.std       = 1'b1; // R14
					next_st.busy      = 1'b1; // R18
					next_st.isten     = 1'b0; // R19
					next_st.ext       = 1'b0; // R8
					next_st.match     = 1'b0; // R9
					next_st.cnt       = I2CSF_CNT_IDLE;
					next_st.addr_ph   = 1'b1;
					next_st.wake_hold = 1'b0; // R3
				end
				if (stop_det) begin
					next_st.spd       = 1'b1; // R15
					next_st.busy      = 1'b0; // R18
					next_st.master    = 1'b0; // R5
					next_st.ext       = 1'b0;
					next_st.match     = 1'b0;
					next_st.std       = 1'b0; // R14
					next_st.ack       = 1'b0; // R13
					next_st.dir       = 1'b0;
					next_st.addr_ph   = 1'b0;
					next_st.gen       = 1'b0;
					next_st.oe_n      = 1'b1;
					next_st.wake_hold = 1'b0; // R3
				end
				if (scl_rise) begin
					next_st.cnt = cnt_new;
					if (cnt_new == I2CSF_CNT_FIRST) begin
						next_st.ack = 1'b0; // R13
						if (st.addr_ph) begin
							next_st.spd = 1'b0; // R15
						end else begin
							next_st.std = 1'b0; // R14
						end
					end
					if (cnt_new <= I2CSF_CNT_ADDR) begin
						next_st.shin = addr_byte;
						if (st.master & st.dir & st.oe_n & ~sda_s) begin
							next_st.arb    = 1'b1; // R6
							next_st.master = 1'b0;
							next_st.dir    = 1'b0;
							next_st.trig   = 1'b0;
						end
					end
					if ((cnt_new == I2CSF_CNT_ADDR) & st.addr_ph) begin
						if ((addr_byte[7:4] == I2CSF_EXT_ZERO) | (addr_byte[7:4] == I2CSF_EXT_ONE)) begin
							next_st.ext = 1'b1; // R8
						end
						if (addr_byte[7:1] == st.own) begin
							next_st.match = 1'b1; // R9
							if (!st.master & addr_byte[0]) begin
								next_st.dir = 1'b1; // R11
							end
						end
						if (st.master & addr_byte[0]) begin
							next_st.dir = 1'b0;
						end
					end
					if (cnt_new == I2CSF_CNT_ACK) begin
						next_st.ack     = ~sda_s; // R13
						next_st.addr_ph = 1'b0;
					end
				end
				// shift latch onto the line on falling clock
				if (scl_fall) begin
					next_st.gen  = 1'b0;
					next_st.oe_n = 1'b1; // R10
					if (st.dir & (st.master | ~st.addr_ph) & (st.cnt != I2CSF_CNT_ADDR)) begin
						next_st.oe_n = st.shout[tx_idx]; // R10
					end
				end
			end
			// software writes
			if (wr & hit(paddr_in, I2CSF_CTRL_IDX)) begin
				next_st.en   = wd[I2CSF_CT_EN];
				next_st.wake = wd[I2CSF_CT_WAKE];
				if (~st.en & wd[I2CSF_CT_EN]) begin
					next_st.busy = ~st.isten; // R18
				end
				if (st.wake & ~wd[I2CSF_CT_WAKE]) begin
					next_st.wake_hold = 1'b1; // R3
					// a stop seen in the same cycle still sets the flag
					if (!stop_det) begin
						next_st.spd = 1'b0; // R15
					end
				end
				if (st.en & wd[I2CSF_CT_START]) begin
					next_st.trig = 1'b1;
					next_st.stcf = 1'b0; // R17
				end
				if (st.en & wd[I2CSF_CT_EXIT]) begin
					next_st.master  = 1'b0; // R5
					next_st.trig    = 1'b0;
					next_st.ext     = 1'b0;
					next_st.match   = 1'b0;
					next_st.dir     = 1'b0;
					next_st.ack     = 1'b0;
					next_st.std     = 1'b0;
					next_st.gen     = 1'b0;
					next_st.addr_ph = 1'b0;
					next_st.oe_n    = 1'b1;
				end
				if (st.en & wd[I2CSF_CT_WREL] & st.dir & (st.cnt == I2CSF_CNT_ACK)) begin
					next_st.dir  = 1'b0; // R12
					next_st.oe_n = 1'b1;
				end
			end
			if (wr & hit(paddr_in, I2CSF_FLAGS_IDX) & ~st.en) begin
				next_st.isten = wd[I2CSF_FL_ISTEN]; // R22
				next_st.rsv   = wd[I2CSF_FL_RSV]; // R21
			end
			if (wr & hit(paddr_in, I2CSF_SHIFT_IDX)) begin
				next_st.shout = wd; // R10
			end
			if (wr & hit(paddr_in, I2CSF_OWN_IDX)) begin
				next_st.own = wd[7:1];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= ST_RESET; // R1
		end else begin
			st <= next_st;
		end
	end

	assign prdata_out                = {24'h000000, st.rdata};
	assign pready_out                = st.pready;
	assign pslverr_out               = st.slverr;
	assign serial_data_line_out      = 1'b0;
	assign serial_data_line_oe_n_out = st.oe_n;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_apb_setup;
		psel_in && !penable_in && ce_in;
	endsequence

	sequence s_start_free;
		ce_in && st.en && st.trig && !st.busy && !st.gen && !st.master && !stop_det;
	endsequence

	a_apb_answer_time: assert property (s_apb_setup ##1 (psel_in && penable_in && ce_in) |=> pready_out) // APB port timing, this design's own decision
		else $error("apb answer not given one cycle into access");
	a_start_gen_master: assert property (s_start_free |=> (st.master && st.dir && !serial_data_line_oe_n_out)) // R5
		else $error("start generation did not claim master and drive data low");
	a_arb_clears_mst: assert property ($rose(st.arb) |-> !st.master && !st.dir) // R6
		else $error("arbitration loss left master or direction set");
	a_arb_read_clear: assert property (ce_in && rd_status && !scl_rise |=> !st.arb) // R7
		else $error("status read did not clear arbitration flag");
	a_ext_code_set: assert property (ce_in && st.en && scl_rise && !stop_det && st.addr_ph && cnt_new == 4'h8
		&& (addr_byte[7:4] == 4'h0 || addr_byte[7:4] == 4'hf) |=> st.ext) // R8
		else $error("extension code not flagged at eighth clock");
	a_match_set: assert property (ce_in && st.en && scl_rise && !stop_det && st.addr_ph && cnt_new == 4'h8
		&& addr_byte[7:1] == st.own |=> st.match) // R9
		else $error("own address not flagged at eighth clock");
	a_ack_ninth: assert property (ce_in && st.en && scl_rise && !stop_det && !wr && cnt_new == 4'h9 && !sda_s
		|=> st.ack) // R13
		else $error("acknowledge not flagged at ninth clock");
	a_start_busy_set: assert property (ce_in && st.en && start_det && !stop_det && !wr |=> st.busy && st.std && !st.isten) // R18
		else $error("start detection did not set busy and start flags");
	a_stop_busy_clr: assert property (ce_in && st.en && stop_det && !wr |=> !st.busy && st.spd && !st.master) // R15
		else $error("stop detection did not release bus flags");
	a_rsv_prohibit: assert property (ce_in && st.en && st.trig && st.busy && st.rsv && !st.gen && !st.master
		&& !stop_det && !wr |=> st.stcf && !st.trig) // R17
		else $error("prohibited reservation not cleared with flag");
	a_wake_hold_view: assert property (ce_in && st.wake_hold && !st.wake |=> $stable(st.view)) // R3
		else $error("status view changed while held after wake fall");
	a_disable_clears: assert property (ce_in && !st.en ##1 ce_in && !st.en
		|-> !st.master && !st.busy && !st.stcf && !st.arb) // R5
		else $error("disabled controller kept flags");

endmodule

//--- tb/i2csf_bus_model.sv
`timescale 1ns/1ps
module i2csf_bus_model (
	// clock
	input  wire logic clk_in,
	// device data pin
	input  wire logic dev_sda_in,
	input  wire logic dev_sda_oe_n_in,
	// wire levels
	output logic      scl_out,
	output logic      sda_out
);
	logic m_sda;

	initial begin
		m_sda = 1'b1;
		scl_out = 1'b1;
	end

	// pulled-up open-drain wire, low if either party pulls
	assign sda_out = m_sda & (dev_sda_oe_n_in | dev_sda_in);

	// half a 64 ns link period
	task automatic half();
		repeat (8) @(posedge clk_in);
	endtask

	task automatic start_c();
		m_sda <= 1'b0;
		half();
		scl_out <= 1'b0;
		half();
	endtask

	task automatic stop_c();
		m_sda <= 1'b0;
		half();
		scl_out <= 1'b1;
		half();
		m_sda <= 1'b1;
		half();
	endtask

	task automatic clk_low();
		scl_out <= 1'b0;
		half();
	endtask

	// data changes only while the clock is low
	task automatic put_bit(input logic b);
		m_sda <= b;
		half();
		scl_out <= 1'b1;
		half();
		scl_out <= 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i]);
		end
		put_bit(~ack);
		half();
	endtask
endmodule

//--- tb/i2csf_top_bench.sv
`timescale 1ns/1ps
module i2csf_top_bench;
	import i2csf_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl;
	logic        sda;
	logic        sda_o;
	logic        sda_oe_n;
	logic [7:0]  rd;
	logic        er;
	int          err_count = 0;
	int          n_checks = 0;

	i2csf_top i_i2csf_top (
		.clk_in                    (clk_in),
		.rst_in                    (rst_in),
		.ce_in                     (ce),
		.psel_in                   (psel),
		.penable_in                (penable),
		.pwrite_in                 (pwrite),
		.paddr_in                  (paddr),
		.pwdata_in                 (pwdata),
		.prdata_out                (prdata),
		.pready_out                (pready),
		.pslverr_out               (pslverr),
		.serial_clock_line_in      (scl),
		.serial_data_line_in       (sda),
		.serial_data_line_out      (sda_o),
		.serial_data_line_oe_n_out (sda_oe_n)
	);

	i2csf_bus_model i_i2csf_bus_model (
		.clk_in          (clk_in),
		.dev_sda_in      (sda_o),
		.dev_sda_oe_n_in (sda_oe_n),
		.scl_out         (scl),
		.sda_out         (sda)
	);

	initial begin
		forever #2 clk_in = ~clk_in;
	end

	task automatic results();
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [31:0] idx, input logic [7:0] wd);
		int n;
		@(posedge clk_in);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {idx[9:0], 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			results();
		end
		rd      = prdata[7:0];
		er      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [31:0] idx, input logic [7:0] exp, input logic [7:0] m, input string nm);
		apb(1'b0, idx, 8'h00);
		chk(nm, exp, rd & m);
	endtask

	task automatic s_reset();
		rdchk(I2CSF_STATUS_IDX, 8'h00, 8'hff, "status reset");
		rdchk(I2CSF_FLAGS_IDX, 8'h00, 8'hff, "flags reset");
		apb(1'b0, 32'h3ff, 8'h00);
		chk("unmapped error", 8'h01, {7'h0, er});
		apb(1'b1, I2CSF_FLAGS_IDX, 8'hff);
		rdchk(I2CSF_FLAGS_IDX, 8'h03, 8'hff, "flags layout");
	endtask

	task automatic s_prohibit();
		apb(1'b1, I2CSF_FLAGS_IDX, 8'h01);
		apb(1'b1, I2CSF_CTRL_IDX, 8'h80);
		rdchk(I2CSF_FLAGS_IDX, 8'h41, 8'hff, "busy on enable");
		apb(1'b1, I2CSF_CTRL_IDX, 8'h82);
		rdchk(I2CSF_FLAGS_IDX, 8'hc1, 8'hff, "start refused");
		rdchk(I2CSF_STATUS_IDX, 8'h00, 8'h80, "no master");
		apb(1'b1, I2CSF_CTRL_IDX, 8'h00);
		rdchk(I2CSF_FLAGS_IDX, 8'h01, 8'hff, "disable clears");
	endtask

	task automatic s_slave();
		apb(1'b1, I2CSF_FLAGS_IDX, 8'h00);
		apb(1'b1, I2CSF_OWN_IDX, 8'ha0);
		apb(1'b1, I2CSF_CTRL_IDX, 8'h80);
		i_i2csf_bus_model.start_c();
		i_i2csf_bus_model.send_byte(8'ha0, 1'b1);
		rdchk(I2CSF_STATUS_IDX, 8'h16, 8'hff, "own address");
		i_i2csf_bus_model.stop_c();
		rdchk(I2CSF_STATUS_IDX, 8'h01, 8'hff, "stop status");
		rdchk(I2CSF_FLAGS_IDX, 8'h00, 8'hff, "bus free");
		// read request to own address, then release the send wait
		i_i2csf_bus_model.start_c();
		i_i2csf_bus_model.send_byte(8'ha1, 1'b1);
		chk("slave drives", 8'h00, {7'h0, sda_oe_n});
		rdchk(I2CSF_STATUS_IDX, 8'h1e, 8'hff, "slave send");
		apb(1'b1, I2CSF_CTRL_IDX, 8'ha0);
		rdchk(I2CSF_STATUS_IDX, 8'h00, 8'h08, "wait release");
		chk("data released", 8'h01, {7'h0, sda_oe_n});
		i_i2csf_bus_model.stop_c();
	endtask

	task automatic s_ext();
		logic [7:0] codes [2] = '{8'h00, 8'hf0};
		// a start made while the clock enable is low goes unseen
		ce <= 1'b0;
		i_i2csf_bus_model.start_c();
		ce <= 1'b1;
		rdchk(I2CSF_FLAGS_IDX, 8'h00, 8'hff, "frozen start");
		i_i2csf_bus_model.stop_c();
		foreach (codes[i]) begin
			i_i2csf_bus_model.start_c();
			i_i2csf_bus_model.send_byte(codes[i], 1'b0);
			rdchk(I2CSF_STATUS_IDX, 8'h22, 8'hff, "extension code");
			i_i2csf_bus_model.stop_c();
		end
	endtask

	task automatic s_wake();
		apb(1'b1, I2CSF_CTRL_IDX, 8'h81);
		i_i2csf_bus_model.start_c();
		i_i2csf_bus_model.send_byte(8'ha0, 1'b1);
		rdchk(I2CSF_STATUS_IDX, 8'h01, 8'hff, "wake view held");
		apb(1'b1, I2CSF_CTRL_IDX, 8'h80);
		rdchk(I2CSF_STATUS_IDX, 8'h01, 8'hff, "wake fall held");
		i_i2csf_bus_model.stop_c();
		rdchk(I2CSF_STATUS_IDX, 8'h01, 8'hff, "wake stop status");
	endtask

	task automatic s_master();
		apb(1'b1, I2CSF_CTRL_IDX, 8'h00);
		apb(1'b1, I2CSF_FLAGS_IDX, 8'h02);
		apb(1'b1, I2CSF_CTRL_IDX, 8'h80);
		rdchk(I2CSF_FLAGS_IDX, 8'h02, 8'hff, "initial start");
		apb(1'b1, I2CSF_SHIFT_IDX, 8'h7f);
		apb(1'b1, I2CSF_CTRL_IDX, 8'h82);
		repeat (16) @(posedge clk_in);
		rdchk(I2CSF_STATUS_IDX, 8'h88, 8'h88, "master send");
		rdchk(I2CSF_FLAGS_IDX, 8'h40, 8'hff, "start seen flags");
		i_i2csf_bus_model.clk_low();
		chk("data driven", 8'h00, {7'h0, sda_oe_n});
		i_i2csf_bus_model.put_bit(1'b1);
		i_i2csf_bus_model.put_bit(1'b0);
		i_i2csf_bus_model.half();
		rdchk(I2CSF_STATUS_IDX, 8'h40, 8'hc0, "arbitration lost");
		rdchk(I2CSF_STATUS_IDX, 8'h00, 8'h40, "lost cleared");
		i_i2csf_bus_model.stop_c();
		rdchk(I2CSF_FLAGS_IDX, 8'h00, 8'h40, "busy after stop");
	endtask

	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		s_reset();
		s_prohibit();
		s_slave();
		s_ext();
		s_wake();
		s_master();
		results();
	end
endmodule
